// ===== rtl/adcf_top.sv
// Converter flag and overrun control with an AXI4-Lite register slave.
// Assumes core events arrive from logic on CLK_I; no pin inputs need synchronising.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module adcf_top (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire adcf_pkg::adcf_core_evt_t CORE_EVT_I,
    input wire adcf_pkg::adcf_imd_t IMD_I,
    output logic CONV_IRQ_O,
    output logic ABORT_PENDING_O,
    output logic START_PENDING_O,
    output logic RESTART_PENDING_O,
    output logic RESTART_RELAUNCH_O,
    output logic HALT_AT_BOUNDARY_O,
    output logic HALT_BEFORE_SAMPLE_O
);
    import adcf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave state

    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic awready_reg;
    logic wready_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    logic aw_take;
    logic w_take;
    logic do_write;
    logic ar_take;
    logic aw_full_next;
    logic w_full_next;
    logic bvalid_next;
    logic rvalid_next;

    function automatic logic [7:0] word_index(input logic [7:0] addr);
        word_index = {2'h0, addr[7:2]};
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx >= IDX_IRQ_FLAGS) && (idx <= IDX_FLOW);
    endfunction

    assign aw_take = S_AXI_AWVALID_I & awready_reg;
    assign w_take = S_AXI_WVALID_I & wready_reg;
    assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign ar_take = S_AXI_ARVALID_I & arready_reg;
    assign aw_full_next = (aw_full_reg & ~do_write) | aw_take;
    assign w_full_next = (w_full_reg & ~do_write) | w_take;
    assign bvalid_next = (bvalid_reg & ~S_AXI_BREADY_I) | do_write;
    assign rvalid_next = (rvalid_reg & ~S_AXI_RREADY_I) | ar_take;

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic [7:0] wr_idx;
    logic wr_lane0;
    logic [7:0] wr_byte;
    logic wr_if;
    logic wr_ie_hi;
    logic wr_ie_lo;
    logic wr_cf_hi;
    logic wr_cf_lo;
    logic wr_ctrl;
    logic wr_flow;

    assign wr_idx = word_index(aw_addr_reg);
    assign wr_lane0 = do_write & w_strb_reg[0];
    assign wr_byte = w_data_reg[7:0];
    assign wr_if = wr_lane0 && (wr_idx == IDX_IRQ_FLAGS);
    assign wr_ie_hi = wr_lane0 && (wr_idx == IDX_IE_HIGH);
    assign wr_ie_lo = wr_lane0 && (wr_idx == IDX_IE_LOW);
    assign wr_cf_hi = wr_lane0 && (wr_idx == IDX_CF_HIGH);
    assign wr_cf_lo = wr_lane0 && (wr_idx == IDX_CF_LOW);
    assign wr_ctrl = wr_lane0 && (wr_idx == IDX_CONTROL);
    assign wr_flow = wr_lane0 && (wr_idx == IDX_FLOW);

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers

    logic [7:0] control_reg;
    logic [15:0] ie_reg;
    logic enable;
    logic soft_reset;
    logic flag_clear;
    logic double_buffer;
    logic auto_start;
    logic restart_aborts;

    assign enable = control_reg[POS_ENABLE];
    assign soft_reset = control_reg[POS_SOFT_RESET];
    assign double_buffer = control_reg[POS_DOUBLE_BUFFER];
    assign auto_start = control_reg[POS_AUTO_START];
    assign restart_aborts = control_reg[POS_RESTART_ABORTS];
    // Soft reset is a level; software must write it back to zero to resume
    assign flag_clear = ~enable | soft_reset;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            control_reg <= RST_CONTROL;
            ie_reg <= RST_IE;
        end else begin
            if (wr_ctrl) begin
                control_reg <= {3'h0, wr_byte[4:0]};
            end
            if (wr_ie_hi) begin
                ie_reg[15:8] <= wr_byte;
            end
            if (wr_ie_lo) begin
                ie_reg[7:0] <= wr_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion flags and overrun detection

    logic [15:0] conv_flags;
    logic [15:0] conv_w1c;
    logic overrun_double;
    logic overrun_single;
    logic flag_overrun;

    assign conv_w1c = {wr_cf_hi ? wr_byte : 8'h00, wr_cf_lo ? wr_byte : 8'h00};
    assign overrun_double = double_buffer & (|(CORE_EVT_I.flag_set & conv_flags));
    // List-end overrun is not reported in single-buffer mode
    assign overrun_single = ~double_buffer & CORE_EVT_I.first_store & (|conv_flags[15:1]);
    assign flag_overrun = overrun_double | overrun_single;

    adcf_flag_bank #(
        .WIDTH(16)
    ) u_conv_flags (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .hold_clear_i(flag_clear),
        .set_i(CORE_EVT_I.flag_set),
        .w1c_i(conv_w1c),
        .flags_o(conv_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequence abort

    logic abort_pending_reg;
    logic abort_quiet_reg;
    logic abort_accept;
    logic abort_done_set;

    // A request while one is pending is dropped, so its quiet attribute is not taken
    assign abort_accept = CORE_EVT_I.abort_req & ~abort_pending_reg;
    assign abort_done_set = abort_pending_reg & CORE_EVT_I.abort_complete & ~abort_quiet_reg;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            abort_pending_reg <= 1'b0;
            abort_quiet_reg <= 1'b0;
        end else if (flag_clear) begin
            abort_pending_reg <= 1'b0;
            abort_quiet_reg <= 1'b0;
        end else if (abort_accept) begin
            abort_pending_reg <= 1'b1;
            abort_quiet_reg <= CORE_EVT_I.abort_hw_lowpower
                | (CORE_EVT_I.in_last_cmd & restart_aborts);
        end else if (CORE_EVT_I.abort_complete) begin
            abort_pending_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter interrupt flags

    logic [7:0] irq_flags;
    logic [7:0] irq_set;
    logic [7:0] irq_w1c;

    assign irq_set = {abort_done_set, flag_overrun, 6'h00};
    assign irq_w1c = wr_if ? {wr_byte[7:6], 6'h00} : 8'h00;

    adcf_flag_bank #(
        .WIDTH(8)
    ) u_irq_flags (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .hold_clear_i(flag_clear),
        .set_i(irq_set),
        .w1c_i(irq_w1c),
        .flags_o(irq_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Restart and start flow

    logic restart_pending;
    logic restart_held;
    logic reload_held;
    logic restart_overrun;
    logic start_pending_reg;
    logic start_err_reg;
    logic halt_boundary_reg;
    logic halt_armed_reg;
    logic halt_sample_reg;
    logic start_overrun;
    logic start_collision;
    logic relaunch_reg;
    logic restart_pending_q;
    logic restart_seen_reg;

    adcf_restart_ctl u_restart (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .clear_i(flag_clear),
        .req_i(CORE_EVT_I.restart_req),
        .done_i(CORE_EVT_I.restart_done),
        .reload_i(CORE_EVT_I.reload_confirm),
        .pending_o(restart_pending),
        .held_o(restart_held),
        .reload_held_o(reload_held),
        .overrun_o(restart_overrun)
    );

    // The restart overrun pulse never reaches the start error path
    assign start_overrun = CORE_EVT_I.start_req & start_pending_reg;
    assign start_collision = auto_start & CORE_EVT_I.hw_start & CORE_EVT_I.start_req;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || flag_clear) begin
            start_pending_reg <= 1'b0;
            start_err_reg <= 1'b0;
            halt_armed_reg <= 1'b0;
            halt_boundary_reg <= 1'b0;
            halt_sample_reg <= 1'b0;
            relaunch_reg <= 1'b0;
        end else begin
            start_pending_reg <= (start_pending_reg & ~CORE_EVT_I.start_taken)
                | CORE_EVT_I.start_req | CORE_EVT_I.hw_start;
            // Error flag set wins over a write-one clear
            start_err_reg <= (start_err_reg & ~(wr_flow & wr_byte[POS_START_OVR_ERR]))
                | start_overrun | start_collision;
            halt_armed_reg <= (halt_armed_reg & ~CORE_EVT_I.boundary) | start_overrun;
            halt_boundary_reg <= halt_boundary_reg | (halt_armed_reg & CORE_EVT_I.boundary);
            halt_sample_reg <= halt_sample_reg | start_collision;
            relaunch_reg <= ~restart_pending_q & restart_pending & restart_seen_reg;
        end
    end

    // Restart relaunch marker: pending rises again right after an overrun was held
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            restart_pending_q <= 1'b0;
            restart_seen_reg <= 1'b0;
        end else begin
            restart_pending_q <= restart_pending;
            restart_seen_reg <= restart_held;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux

    logic [7:0] rd_idx;
    logic [7:0] rd_byte;
    logic [7:0] flow_status;

    assign rd_idx = word_index(S_AXI_ARADDR_I);
    assign flow_status = {abort_pending_reg, start_pending_reg, restart_pending, reload_held,
        2'h0, start_err_reg, restart_held};
    assign rd_byte = (rd_idx == IDX_IRQ_FLAGS) ? irq_flags :
                     (rd_idx == IDX_IE_HIGH) ? ie_reg[15:8] :
                     (rd_idx == IDX_IE_LOW) ? ie_reg[7:0] :
                     (rd_idx == IDX_CF_HIGH) ? conv_flags[15:8] :
                     (rd_idx == IDX_CF_LOW) ? conv_flags[7:0] :
                     (rd_idx == IDX_IMD_SEL) ? {IMD_I.list_select, IMD_I.result_select, 6'h00} :
                     (rd_idx == IDX_IMD_IDX) ? {2'h0, IMD_I.result_index} :
                     (rd_idx == IDX_CONTROL) ? control_reg :
                     (rd_idx == IDX_FLOW) ? flow_status : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake registers

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= AXI_OKAY;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= AXI_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            bvalid_reg <= bvalid_next;
            rvalid_reg <= rvalid_next;
            awready_reg <= ~aw_full_next;
            wready_reg <= ~w_full_next;
            arready_reg <= ~rvalid_next;
            if (aw_take) begin
                aw_addr_reg <= S_AXI_AWADDR_I;
            end
            if (w_take) begin
                w_data_reg <= S_AXI_WDATA_I;
                w_strb_reg <= S_AXI_WSTRB_I;
            end
            if (do_write) begin
                bresp_reg <= mapped(wr_idx) ? AXI_OKAY : AXI_SLVERR;
            end
            if (ar_take) begin
                rdata_reg <= {24'h00_0000, rd_byte};
                rresp_reg <= mapped(rd_idx) ? AXI_OKAY : AXI_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    logic conv_irq_reg;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            conv_irq_reg <= 1'b0;
        end else begin
            conv_irq_reg <= |(conv_flags & ie_reg);
        end
    end

    assign S_AXI_AWREADY_O = awready_reg;
    assign S_AXI_WREADY_O = wready_reg;
    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_BRESP_O = bresp_reg;
    assign S_AXI_ARREADY_O = arready_reg;
    assign S_AXI_RVALID_O = rvalid_reg;
    assign S_AXI_RDATA_O = rdata_reg;
    assign S_AXI_RRESP_O = rresp_reg;
    assign CONV_IRQ_O = conv_irq_reg;
    assign ABORT_PENDING_O = abort_pending_reg;
    assign START_PENDING_O = start_pending_reg;
    assign RESTART_PENDING_O = restart_pending_q;
    assign RESTART_RELAUNCH_O = relaunch_reg;
    assign HALT_AT_BOUNDARY_O = halt_boundary_reg;
    assign HALT_BEFORE_SAMPLE_O = halt_sample_reg;
endmodule
`default_nettype wire

// ===== rtl/adcf_pkg.sv
// Constants and carrier types for the converter flag and overrun control block.
// Assumes a 32-bit AXI4-Lite register bus and a converter core on the same clock.
package adcf_pkg;
    // Printed offsets are register indices; the byte address is four times the index
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h09;
    localparam logic [7:0] IDX_IE_HIGH = 8'h0A;
    localparam logic [7:0] IDX_IE_LOW = 8'h0B;
    localparam logic [7:0] IDX_CF_HIGH = 8'h0C;
    localparam logic [7:0] IDX_CF_LOW = 8'h0D;
    localparam logic [7:0] IDX_IMD_SEL = 8'h0E;
    localparam logic [7:0] IDX_IMD_IDX = 8'h0F;
    localparam logic [7:0] IDX_CONTROL = 8'h10;
    localparam logic [7:0] IDX_FLOW = 8'h11;
    // Converter interrupt flag bit positions
    localparam int POS_ABORT_DONE = 7;
    localparam int POS_FLAG_OVERRUN = 6;
    // Control register bit positions
    localparam int POS_ENABLE = 0;
    localparam int POS_SOFT_RESET = 1;
    localparam int POS_RESTART_ABORTS = 2;
    localparam int POS_DOUBLE_BUFFER = 3;
    localparam int POS_AUTO_START = 4;
    // Flow register bit positions
    localparam int POS_ABORT_PENDING = 7;
    localparam int POS_START_PENDING = 6;
    localparam int POS_RESTART_PENDING = 5;
    localparam int POS_RELOAD_HELD = 4;
    localparam int POS_START_OVR_ERR = 1;
    localparam int POS_RESTART_HELD = 0;
    // Reset values and AXI response codes
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [15:0] RST_IE = 16'h0000;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Per-cycle events from the converter core; all are one-cycle pulses except levels noted
    typedef struct packed {
        logic [15:0] flag_set;      // [15:1] per-conversion flag set, [0] list-end flag set
        logic first_store;          // First result of a command list being stored
        logic abort_req;            // Sequence abort request
        logic abort_hw_lowpower;    // Abort request made by hardware for stop or wait entry
        logic in_last_cmd;          // Level: last command of the list executing
        logic abort_complete;       // Abort event has been executed
        logic restart_req;          // Legal restart request
        logic restart_done;         // Restart event finished
        logic reload_confirm;       // Level: reload-confirm input
        logic start_req;            // Start request via bus or internal interface
        logic hw_start;             // Automatic start made by a restart
        logic start_taken;          // Start request consumed by the sequencer
        logic boundary;             // Conversion boundary reached
        logic sampling;             // Sampling about to begin
    } adcf_core_evt_t;

    typedef struct packed {
        logic list_select;
        logic result_select;
        logic [5:0] result_index;
    } adcf_imd_t;
endpackage

// ===== rtl/adcf_flag_bank.sv
// Bank of sticky flags: hardware sets, software clears by writing one.
// Assumes set and write-clear vectors on the same clock as the bank.
`timescale 1ns/10ps
`default_nettype none
module adcf_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hold_clear_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] w1c_i,
    output logic [WIDTH-1:0] flags_o
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // A set in the same cycle as a write-one clear survives
    assign flags_next = hold_clear_i ? '0 : ((flags_reg & ~w1c_i) | set_i);
    assign flags_o = flags_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/adcf_restart_ctl.sv
// Restart request tracking with one held overrun request and a reload-confirm background bit.
// Assumes request and done pulses from the sequencer on the same clock.
`timescale 1ns/10ps
`default_nettype none
module adcf_restart_ctl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic req_i,
    input wire logic done_i,
    input wire logic reload_i,
    output logic pending_o,
    output logic held_o,
    output logic reload_held_o,
    output logic overrun_o
);
    logic pending_reg;
    logic held_reg;
    logic reload_reg;
    logic relaunch_reg;
    logic overrun;
    logic accept;

    // A request in the cycle the restart ends is still counted as overrun and relaunched
    assign overrun = req_i & pending_reg;
    assign accept = req_i & ~pending_reg & ~relaunch_reg;
    assign pending_o = pending_reg;
    assign held_o = held_reg;
    assign reload_held_o = reload_reg;
    assign overrun_o = overrun;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_i) begin
            pending_reg <= 1'b0;
            held_reg <= 1'b0;
            reload_reg <= 1'b0;
            relaunch_reg <= 1'b0;
        end else begin
            relaunch_reg <= done_i & pending_reg & (held_reg | overrun);
            if (relaunch_reg) begin
                pending_reg <= 1'b1;
                held_reg <= 1'b0;
                reload_reg <= 1'b0;
            end else begin
                pending_reg <= accept | (pending_reg & ~done_i);
                held_reg <= held_reg | overrun;
                reload_reg <= reload_reg | (overrun & reload_i);
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/adcf_top_props.sv
// Port checks for the converter flag and overrun control block.
// Assumes binding to adcf_top: one clock, synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module adcf_top_props (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire adcf_pkg::adcf_core_evt_t CORE_EVT_I,
    input wire logic ABORT_PENDING_O,
    input wire logic START_PENDING_O,
    input wire logic RESTART_PENDING_O,
    input wire logic RESTART_RELAUNCH_O,
    input wire logic HALT_AT_BOUNDARY_O,
    input wire logic HALT_BEFORE_SAMPLE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    sequence relaunch_seen;
        RESTART_RELAUNCH_O && RESTART_PENDING_O;
    endsequence
    ////////////////////////////////////////
    wr_answer_a:
        assert property (wr_taken |-> ##2 S_AXI_BVALID_O) else $error("write not answered");
    bresp_hold_a:
        assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped");
    rd_answer_a:
        assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O) else $error("read not answered");
    abort_rise_a:
        assert property ($rose(ABORT_PENDING_O) |-> $past(CORE_EVT_I.abort_req)) else $error("abort unasked");
    abort_done_a:
        assert property (ABORT_PENDING_O && CORE_EVT_I.abort_complete |=> !ABORT_PENDING_O) else $error("abort stuck");
    abort_drop_a:
        assert property (ABORT_PENDING_O && CORE_EVT_I.abort_req && !CORE_EVT_I.abort_complete |=> ABORT_PENDING_O)
        else $error("repeat abort disturbed pending");
    start_rise_a:
        assert property ($rose(START_PENDING_O) |-> $past(CORE_EVT_I.start_req) || $past(CORE_EVT_I.hw_start))
        else $error("start pending unasked");
    halt_bnd_a:
        assert property ($rose(HALT_AT_BOUNDARY_O) |-> $past(CORE_EVT_I.boundary) || $past(CORE_EVT_I.boundary, 2))
        else $error("halt without boundary");
    halt_smp_a:
        assert property ($rose(HALT_BEFORE_SAMPLE_O) |-> $past(CORE_EVT_I.hw_start) || $past(CORE_EVT_I.hw_start, 2))
        else $error("halt without collision");
    relaunch_a:
        assert property (relaunch_seen |=> !RESTART_RELAUNCH_O) else $error("relaunch not a pulse");
endmodule
`default_nettype wire

// ===== tb/adcf_top_tb.sv
// Self-checking bench for the converter flag and overrun control block.
// Assumes the package register map; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module adcf_top_tb;
    import adcf_pkg::*;
    logic CLK_I = '0, RST_N_I = '0, S_AXI_AWVALID_I = '0, S_AXI_WVALID_I = '0, S_AXI_BREADY_I = '0;
    logic S_AXI_ARVALID_I = '0, S_AXI_RREADY_I = '0, S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
    logic S_AXI_ARREADY_O, S_AXI_RVALID_O, CONV_IRQ_O, ABORT_PENDING_O, START_PENDING_O;
    logic RESTART_PENDING_O, RESTART_RELAUNCH_O, HALT_AT_BOUNDARY_O, HALT_BEFORE_SAMPLE_O;
    logic [7:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
    logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O;
    logic [3:0] S_AXI_WSTRB_I = 4'hF;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    adcf_core_evt_t CORE_EVT_I = '0;
    adcf_imd_t IMD_I = 8'hA5;
    int miscompares = 0, n_checks = 0;
    always #25 CLK_I = ~CLK_I;
    adcf_top adcf_top_inst (.*);
    task automatic summarize;
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 40) begin
            miscompares++;
            summarize;
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r = AXI_OKAY);
        int n;
        n = 0;
        S_AXI_AWADDR_I <= {i[5:0], 2'h0};
        S_AXI_WDATA_I <= {24'h00_0000, d};
        S_AXI_AWVALID_I <= 1'h1;
        S_AXI_WVALID_I <= 1'h1;
        S_AXI_BREADY_I <= 1'h1;
        do begin
            @(posedge CLK_I);
            n++;
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'h0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'h0;
        end while (S_AXI_BVALID_O !== 1'h1 && n < 40);
        S_AXI_BREADY_I <= 1'h0;
        tmo(n);
        chk("bresp", r, S_AXI_BRESP_O);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] r = AXI_OKAY);
        int n;
        n = 0;
        S_AXI_ARADDR_I <= {i[5:0], 2'h0};
        S_AXI_ARVALID_I <= 1'h1;
        S_AXI_RREADY_I <= 1'h1;
        do begin
            @(posedge CLK_I);
            n++;
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'h0;
        end while (S_AXI_RVALID_O !== 1'h1 && n < 40);
        S_AXI_RREADY_I <= 1'h0;
        tmo(n);
        chk($sformatf("rresp %h", i), r, S_AXI_RRESP_O);
        chk($sformatf("reg %h", i), e, S_AXI_RDATA_O);
    endtask
    // Two idle edges after the pulse so registered outputs have settled
    task automatic ev(input adcf_core_evt_t e);
        CORE_EVT_I <= e;
        @(posedge CLK_I);
        CORE_EVT_I <= '0;
        repeat (2) @(posedge CLK_I);
    endtask
    ////////////////////////////////////////
    initial begin
        int n;
        repeat (6) @(posedge CLK_I);
        RST_N_I <= 1'h1;
        repeat (2) @(posedge CLK_I);
        rd(IDX_CONTROL, RST_CONTROL);
        rd(IDX_IE_LOW, RST_IE[7:0]);
        rd(8'h20, 8'h00, AXI_SLVERR);
        wr(8'h20, 8'hFF, AXI_SLVERR);
        ev('{default: '0, flag_set: 16'hFFFF});
        rd(IDX_CF_HIGH, 8'h00);
        wr(IDX_CONTROL, 8'h01);
        rd(IDX_IMD_SEL, 8'h80);
        rd(IDX_IMD_IDX, 8'h25);
        ev('{default: '0, flag_set: 16'h0003});
        rd(IDX_CF_LOW, 8'h03);
        chk("irq", 1'h0, CONV_IRQ_O);
        wr(IDX_IE_LOW, 8'h02);
        rd(IDX_IE_LOW, 8'h02);
        chk("irq", 1'h1, CONV_IRQ_O);
        wr(IDX_CF_LOW, 8'h00);
        wr(IDX_CF_LOW, 8'h05);
        rd(IDX_CF_LOW, 8'h02);
        ev('{default: '0, first_store: 1'h1});
        rd(IDX_IRQ_FLAGS, 8'h40);
        wr(IDX_IRQ_FLAGS, 8'h40);
        rd(IDX_IRQ_FLAGS, 8'h00);
        wr(IDX_CONTROL, 8'h09);
        ev('{default: '0, flag_set: 16'h0002});
        rd(IDX_IRQ_FLAGS, 8'h40);
        wr(IDX_CONTROL, 8'h05);
        for (int k = 0; k < 3; k++) begin
            wr(IDX_IRQ_FLAGS, 8'hC0);
            ev('{default: '0, abort_req: 1'h1, abort_hw_lowpower: k == 1, in_last_cmd: k == 2});
            chk("abort pending", 1'h1, ABORT_PENDING_O);
            ev('{default: '0, abort_req: 1'h1, abort_hw_lowpower: 1'h1});
            ev('{default: '0, abort_complete: 1'h1});
            rd(IDX_IRQ_FLAGS, k == 0 ? 8'h80 : 8'h00);
        end
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_CONTROL, 8'h11);
        ev('{default: '0, restart_req: 1'h1});
        chk("restart pending", 1'h1, RESTART_PENDING_O);
        rd(IDX_FLOW, 8'h20);
        ev('{default: '0, restart_req: 1'h1, reload_confirm: 1'h1});
        ev('{default: '0, restart_req: 1'h1});
        rd(IDX_FLOW, 8'h31);
        CORE_EVT_I <= '{default: '0, restart_done: 1'h1};
        n = 0;
        do begin
            @(posedge CLK_I);
            CORE_EVT_I <= '0;
            n++;
        end while (RESTART_RELAUNCH_O !== 1'h1 && n < 10);
        chk("relaunch", 1'h1, RESTART_RELAUNCH_O);
        rd(IDX_FLOW, 8'h20);
        ev('{default: '0, restart_done: 1'h1});
        ev('{default: '0, start_req: 1'h1});
        chk("halt", 1'h0, HALT_AT_BOUNDARY_O);
        chk("start pending", 1'h1, START_PENDING_O);
        ev('{default: '0, start_req: 1'h1});
        rd(IDX_FLOW, 8'h42);
        ev('{default: '0, boundary: 1'h1});
        chk("halt", 1'h1, HALT_AT_BOUNDARY_O);
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_CONTROL, 8'h11);
        ev('{default: '0, hw_start: 1'h1, start_req: 1'h1});
        chk("halt sample", 1'h1, HALT_BEFORE_SAMPLE_O);
        ev('{default: '0, flag_set: 16'h0002});
        wr(IDX_CONTROL, 8'h13);
        rd(IDX_CF_LOW, 8'h00);
        summarize;
    end
endmodule
bind adcf_top adcf_top_props adcf_top_props_inst (.*);
`default_nettype wire
